// File: dv/gas_reading_pulse_output_tb.sv
/* Self-checking bench for grpo_top.
   Assumes the reader model and the bound checker. */
`timescale 1ns/10ps
module gas_reading_pulse_output_tb;
   typedef struct packed {logic [15:0] ppm; logic [31:0] res; logic meas;} grpo_row_t;
   localparam grpo_row_t ROWS [7] = '{'{16'hFFFF, 32'hFFFF_2710, 1'b0}, '{16'h2EE0, 32'h2EE0_2710, 1'b0},
      '{16'h2710, 32'h2710_2710, 1'b0}, '{16'h0000, 32'h0000_0000, 1'b0}, '{16'h0001, 32'h0001_0001, 1'b1},
      '{16'h0008, 32'h0008_0008, 1'b1}, '{16'h0050, 32'h0050_0050, 1'b1}};
   logic        clk, rst, hwrite, hready, pin, done, start, cont, pulse, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [15:0] ppm, rd_ppm;
   logic [7:0]  rd_falls, f0;
   int          error_cnt, num_checks, cyc, n;
   grpo_top uut (.core_clk_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .pulse_output_inhibit_pin_i(pin), .meas_done_i(done),
      .meas_ppm_i(ppm), .meas_start_o(start), .meas_cont_o(cont), .pulse_o(pulse));
   grpo_reader u_rd (.core_clk_i(clk), .rst_i(rst), .pulse_i(pulse), .ppm_o(rd_ppm), .falls_o(rd_falls));
   // ==========================================
   // Tasks
   // ==========================================
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rdata = hrdata;
   endtask
   task automatic md(input logic [15:0] p);
      @(posedge clk);
      done <= 1'b1;
      ppm <= p;
      @(posedge clk);
      done <= 1'b0;
   endtask
   task automatic wait_fall;
      f0 = rd_falls;
      for (n = 0; n < 12000 && rd_falls === f0; n++) @(posedge clk);
   endtask
   // ==========================================
   // Clock, timeout and sequence
   // ==========================================
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         test_done();
      end
   end
   initial
   begin
      {rst, hwrite, pin, done, htrans, haddr, hwdata, ppm} = '0;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (n = 0; n < 40 && start !== 1'b1; n++) @(posedge clk);
      @(posedge clk);
      check(cont === 1'b1 && n < 40, "no boot start");
      bus(1'b1, grpo_pkg::CTRL_OFS, 32'h0000_0001);
      $display("boot test done");
      foreach (ROWS[i])
      begin
         md(ROWS[i].ppm);
         bus(1'b0, grpo_pkg::RESULT_OFS, grpo_pkg::ZERO_WORD);
         check(rdata === ROWS[i].res, "result word");
         if (ROWS[i].meas)
         begin
            wait_fall();
            check(rd_ppm === ROWS[i].ppm, "pulse width");
         end
      end
      $display("row tests done");
      bus(1'b1, grpo_pkg::CTRL_OFS, 32'h0000_0003);
      bus(1'b0, grpo_pkg::CTRL_OFS, grpo_pkg::ZERO_WORD);
      check(rdata === 32'h0000_0003, "ctrl readback");
      md(16'h0008);
      wait_fall();
      bus(1'b0, grpo_pkg::STATUS_OFS, grpo_pkg::ZERO_WORD);
      check(rdata[grpo_pkg::ST_BUSY_BIT] === 1'b1 && rd_ppm === 16'h0008, "train");
      bus(1'b1, grpo_pkg::CTRL_OFS, grpo_pkg::ZERO_WORD);
      md(16'h0008);
      repeat (3) @(posedge clk);
      check(pulse === 1'b0, "pulse while disabled");
      bus(1'b1, grpo_pkg::CTRL_OFS, 32'h0000_0005);
      md(16'h0050);
      repeat (100) @(posedge clk);
      check(pulse === 1'b1 && cont === 1'b1, "pulse missing");
      pin <= 1'b1;
      repeat (3) @(posedge clk);
      check(pulse === 1'b0, "pulse while inhibited");
      md(16'h0008);
      repeat (2) @(posedge clk);
      check(cont === 1'b0, "continuous kept");
      pin <= 1'b0;
      bus(1'b1, grpo_pkg::CTRL_OFS, 32'h0000_0008);
      repeat (30) @(posedge clk);
      bus(1'b0, grpo_pkg::CTRL_OFS, grpo_pkg::ZERO_WORD);
      check(cont === 1'b0 && rdata === grpo_pkg::CTRL_RESET, "soft reset");
      $display("hand tests done");
      pin <= 1'b1;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (30) @(posedge clk);
      bus(1'b0, grpo_pkg::STATUS_OFS, grpo_pkg::ZERO_WORD);
      check(cont === 1'b0 && rdata[grpo_pkg::ST_BOOTED_BIT] === 1'b1, "inhibited boot");
      check(rdata[grpo_pkg::ST_PIN_BIT] === 1'b1, "pin status");
      bus(1'b0, 8'h0C, grpo_pkg::ZERO_WORD);
      check(rdata === grpo_pkg::ZERO_WORD, "unmapped read");
      $display("reset tests done");
      test_done();
   end
endmodule

// File: dv/grpo_reader.sv
/* Pulse-width reader at the far side of the pulse output.
   Assumes 125 core cycles per ppm. */
`timescale 1ns/10ps
module grpo_reader
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        pulse_i,
   output logic      [15:0] ppm_o,
   output logic      [7:0]  falls_o
);
   logic [31:0] high_cnt;
   // ==========================================
   // High time to ppm
   // ==========================================
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         high_cnt <= 32'h0000_0000;
         ppm_o <= 16'h0000;
         falls_o <= 8'h00;
      end
      else if (pulse_i)
         high_cnt <= high_cnt + 32'h0000_0001;
      else if (high_cnt != 32'h0000_0000)
      begin
         ppm_o <= 16'(high_cnt / 32'h0000_007D);
         falls_o <= falls_o + 8'h01;
         high_cnt <= 32'h0000_0000;
      end
   end
endmodule

// File: dv/grpo_top_asserts.sv
/* Port checker for grpo_top.
   Assumes one clock and the asynchronous active-high reset. */
`timescale 1ns/10ps
module grpo_top_asserts
(
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        pulse_output_inhibit_pin_i,
   input wire logic        meas_done_i,
   input wire logic [15:0] meas_ppm_i,
   input wire logic        meas_start_o,
   input wire logic        meas_cont_o,
   input wire logic        pulse_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [4:0] cyc;
   // ==========================================
   // Cycles since reset release
   // ==========================================
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         cyc <= 5'h00;
      else if (cyc != 5'h1F)
         cyc <= cyc + 5'h01;
   // ==========================================
   // Properties
   // ==========================================
   chk_ready_high: assert property (hreadyout_o) else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp_o) else $error("hresp not okay");
   chk_pin_mutes: assert property ($past(pulse_output_inhibit_pin_i) && pulse_output_inhibit_pin_i |-> !pulse_o)
      else $error("pulse while inhibited");
   chk_idle_on_pin: assert property (meas_done_i && pulse_output_inhibit_pin_i |=> !meas_cont_o)
      else $error("continuous kept");
   chk_no_pulse_pin: assert property (meas_done_i && pulse_output_inhibit_pin_i |=> !pulse_o)
      else $error("pulse after inhibit");
   chk_zero_duty: assert property (meas_done_i && meas_ppm_i == 16'h0000 |=> !pulse_o)
      else $error("pulse at zero ppm");
   chk_start_single: assert property (meas_start_o |=> !meas_start_o) else $error("start too long");
   chk_boot_wait: assert property (cyc < 5'h11 |-> !meas_start_o && !meas_cont_o)
      else $error("start before boot");
   cov_start: cover property (meas_start_o);
   cov_fall: cover property ($fell(pulse_o));
   cov_inhibit: cover property (meas_done_i && pulse_output_inhibit_pin_i);
endmodule
bind grpo_top grpo_top_asserts u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .pulse_output_inhibit_pin_i(pulse_output_inhibit_pin_i), .meas_done_i(meas_done_i),
   .meas_ppm_i(meas_ppm_i), .meas_start_o(meas_start_o), .meas_cont_o(meas_cont_o), .pulse_o(pulse_o));

// File: pkg/grpo_pkg.sv
/*
   Constants and types for the gas reading pulse output block.
   Assumes a 100 MHz core clock and a single AHB-Lite master.
*/
package grpo_pkg;

   // ===========================================================
   // Timing
   // ===========================================================
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned CLK_PS       = 10_000;
   localparam int unsigned BASE_HZ      = 80;
   localparam int unsigned TICK_PS      = 1_250_000;
   localparam int unsigned TICK_CYCLES  = (TICK_PS + CLK_PS - 1) / CLK_PS;
   localparam int unsigned PERIOD_TICKS = CLK_HZ / BASE_HZ / TICK_CYCLES;
   localparam int unsigned FULL_PPM     = 10_000;
   localparam logic [7:0]  TRAIN_PULSES = 8'hA0;
   localparam logic [7:0]  SINGLE_PULSE = 8'h01;
   localparam logic [7:0]  BOOT_CYCLES  = 8'h10;

   // ===========================================================
   // Register map
   // ===========================================================
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] RESULT_OFS = 8'h08;

   localparam int unsigned CTRL_OUT_EN_BIT = 0;
   localparam int unsigned CTRL_TRAIN_BIT  = 1;
   localparam int unsigned CTRL_CONT_BIT   = 2;
   localparam int unsigned CTRL_SRST_BIT   = 3;

   localparam int unsigned ST_BOOTED_BIT = 0;
   localparam int unsigned ST_CONT_BIT   = 1;
   localparam int unsigned ST_BUSY_BIT   = 2;
   localparam int unsigned ST_PIN_BIT    = 3;
   localparam int unsigned ST_PULSE_BIT  = 4;

   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   // ===========================================================
   // Types
   // ===========================================================
   typedef enum logic [0:0] {GRPO_BOOTING, GRPO_RUNNING} grpo_phase_t;

   typedef struct packed {
      logic        out_en;
      logic        train;
   } grpo_cfg_t;

   typedef struct packed {
      logic        done;
      logic [15:0] ppm;
   } grpo_result_t;

   typedef struct packed {
      grpo_phase_t  phase;
      logic [7:0]   boot_cnt;
      grpo_cfg_t    cfg;
      logic         cont;
      logic         meas_start;
      logic [15:0]  ppm_raw;
      logic [13:0]  high_ticks;
      logic [6:0]   prescale;
      logic [13:0]  tick;
      logic [7:0]   pulses_left;
      logic         pulse;
      logic         dphase_wr;
      logic [7:0]   dphase_addr;
      logic [31:0]  hrdata;
      logic         hreadyout;
   } grpo_state_t;

endpackage

// File: rtl/grpo_top.sv
/*
   Pulse-width output that reports the measured gas concentration,
   with an AHB-Lite register slave and the post-boot inhibit check.
   Assumes the measurement engine outside starts on meas_start_o,
   runs while meas_cont_o is high and reports each result with one pulse.
*/
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
// Notes on behaviour
// - Inhibit pin sampled once after power-on boot, never after soft reset.
// - Low post-boot sample enters continuous mode and starts a measurement.
// - After each measurement, high inhibit pin returns to idle, output off.
// - Each finished measurement loads its concentration into pulse timing.
// - Output active only with software enable set and inhibit pin low.
// - Every pulse period runs at a fixed 80 Hz base.
// - Duty maps linearly from 0% at 0 ppm to 100% at 10000 ppm.
// - High time grows 1.25 us per ppm.
// - Configuration selects single-pulse or pulse-train operation.
// - Single-pulse operation emits one pulse per result, then idles.
// - Pulse-train operation emits 160 pulses per result, then idles.
`timescale 1ns/10ps

module grpo_top
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        pulse_output_inhibit_pin_i,
   input  wire logic        meas_done_i,
   input  wire logic [15:0] meas_ppm_i,
   output logic             meas_start_o,
   output logic             meas_cont_o,
   output logic             pulse_o
);

   // ===========================================================
   // State
   // ===========================================================
   grpo_pkg::grpo_state_t  state;
   grpo_pkg::grpo_state_t  next_state;
   grpo_pkg::grpo_result_t result;
   logic                   addr_phase;
   logic                   wr_ctrl;
   logic                   pin_low;

   assign result.done = meas_done_i;
   assign result.ppm  = meas_ppm_i;
   assign pin_low     = ~pulse_output_inhibit_pin_i;
   assign addr_phase  = hsel_i & htrans_i[1] & hready_i;
   assign wr_ctrl     = state.dphase_wr & (state.dphase_addr == grpo_pkg::CTRL_OFS);

   // ===========================================================
   // Helpers
   // ===========================================================
   function automatic logic [13:0] clamp_ticks(input logic [15:0] ppm);
      begin
         if (32'(ppm) > grpo_pkg::FULL_PPM)
         begin
            clamp_ticks = 14'(grpo_pkg::PERIOD_TICKS);
         end
         else
         begin
            clamp_ticks = ppm[13:0];
         end
      end
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] ofs,
                                             input grpo_pkg::grpo_state_t s,
                                             input logic pin);
      begin
         read_word = grpo_pkg::ZERO_WORD;
         if (ofs == grpo_pkg::CTRL_OFS)
         begin
            read_word[grpo_pkg::CTRL_OUT_EN_BIT] = s.cfg.out_en;
            read_word[grpo_pkg::CTRL_TRAIN_BIT]  = s.cfg.train;
            read_word[grpo_pkg::CTRL_CONT_BIT]   = s.cont;
         end
         else if (ofs == grpo_pkg::STATUS_OFS)
         begin
            read_word[grpo_pkg::ST_BOOTED_BIT] = (s.phase == grpo_pkg::GRPO_RUNNING);
            read_word[grpo_pkg::ST_CONT_BIT]   = s.cont;
            read_word[grpo_pkg::ST_BUSY_BIT]   = (s.pulses_left != 8'h00);
            read_word[grpo_pkg::ST_PIN_BIT]    = pin;
            read_word[grpo_pkg::ST_PULSE_BIT]  = s.pulse;
         end
         else if (ofs == grpo_pkg::RESULT_OFS)
         begin
            read_word[13:0]  = s.high_ticks;
            read_word[31:16] = s.ppm_raw;
         end
      end
   endfunction

   // ===========================================================
   // Next state
   // ===========================================================
   always_comb
   begin
      next_state            = state;
      next_state.meas_start = 1'b0;
      next_state.hreadyout  = 1'b1;

      // Register slave: address phase captured, write applied in data phase.
      next_state.dphase_wr = addr_phase & hwrite_i;
      if (addr_phase)
      begin
         next_state.dphase_addr = haddr_i[7:0];
         next_state.hrdata      = hwrite_i ? grpo_pkg::ZERO_WORD
                                           : read_word(haddr_i[7:0], state, pulse_output_inhibit_pin_i);
      end
      if (wr_ctrl)
      begin
         next_state.cfg.out_en = hwdata_i[grpo_pkg::CTRL_OUT_EN_BIT];
         next_state.cfg.train  = hwdata_i[grpo_pkg::CTRL_TRAIN_BIT];
         next_state.cont       = hwdata_i[grpo_pkg::CTRL_CONT_BIT];
         if (hwdata_i[grpo_pkg::CTRL_CONT_BIT] & ~state.cont)
         begin
            next_state.meas_start = 1'b1;
         end
      end

      // Boot check happens once; a soft reset does not revisit it.
      unique case (state.phase)
         grpo_pkg::GRPO_BOOTING:
         begin
            if (state.boot_cnt == grpo_pkg::BOOT_CYCLES)
            begin
               next_state.phase = grpo_pkg::GRPO_RUNNING;
               if (pin_low)
               begin
                  next_state.cont       = 1'b1;
                  next_state.meas_start = 1'b1;
               end
            end
            else
            begin
               next_state.boot_cnt = state.boot_cnt + 8'h01;
            end
         end
         grpo_pkg::GRPO_RUNNING:
         begin
         end
      endcase

      // Pulse timing: 125-cycle ticks, 10000 ticks per period.
      if (state.pulses_left != 8'h00)
      begin
         if (32'(state.prescale) == grpo_pkg::TICK_CYCLES - 1)
         begin
            next_state.prescale = 7'h00;
            if (32'(state.tick) == grpo_pkg::PERIOD_TICKS - 1)
            begin
               next_state.tick        = 14'h0000;
               next_state.pulses_left = state.pulses_left - 8'h01;
            end
            else
            begin
               next_state.tick = state.tick + 14'h0001;
            end
         end
         else
         begin
            next_state.prescale = state.prescale + 7'h01;
         end
      end

      // End of a measurement: reload timing, then poll the inhibit pin.
      if (result.done & (state.phase == grpo_pkg::GRPO_RUNNING))
      begin
         next_state.ppm_raw    = result.ppm;
         next_state.high_ticks = clamp_ticks(result.ppm);
         next_state.prescale   = 7'h00;
         next_state.tick       = 14'h0000;
         if (pin_low)
         begin
            next_state.pulses_left = next_state.cfg.train ? grpo_pkg::TRAIN_PULSES
                                                          : grpo_pkg::SINGLE_PULSE;
         end
         else
         begin
            next_state.cont        = 1'b0;
            next_state.pulses_left = 8'h00;
         end
      end

      // Soft reset clears configuration and stops any output.
      if (wr_ctrl & hwdata_i[grpo_pkg::CTRL_SRST_BIT])
      begin
         next_state.cfg         = '0;
         next_state.cont        = 1'b0;
         next_state.meas_start  = 1'b0;
         next_state.pulses_left = 8'h00;
         next_state.prescale    = 7'h00;
         next_state.tick        = 14'h0000;
      end

      next_state.pulse = (next_state.pulses_left != 8'h00)
                       & (next_state.tick < next_state.high_ticks)
                       & next_state.cfg.out_en & pin_low;
   end

   // ===========================================================
   // Registers
   // ===========================================================
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state           <= '0;
         state.phase     <= grpo_pkg::GRPO_BOOTING;
         state.hreadyout <= 1'b1;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ===========================================================
   // Outputs
   // ===========================================================
   assign hrdata_o     = state.hrdata;
   assign hreadyout_o  = state.hreadyout;
   assign hresp_o      = 1'b0;
   assign meas_start_o = state.meas_start;
   assign meas_cont_o  = state.cont;
   assign pulse_o      = state.pulse;

endmodule
